// *** hw/ecp_top.sv ***
module ecp_top import ecp_pkg::*; #(
  parameter int TRIG_W = TRIG_WIDTH_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Active-low command pins from the controller
  input wire logic output_off_n,
  input wire logic output_on_n,
  input wire logic seq_start_n,
  input wire logic seq_stop_n,
  input wire logic seq_hold_n,
  input wire logic seq_branch1_n,
  input wire logic seq_branch2_n,
  // State from the power stage and sequence engine
  input wire ecp_engine_t engine,
  input wire logic trigger_req,
  // Decoded commands to the sequence engine, one-cycle pulses
  output ecp_cmd_t cmd,
  // Status pins
  output ecp_pins_t pins,
  output logic irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (TRIG_W < 1 || TRIG_W > 16) begin : g_chk
    $error("ecp_top: TRIG_W must be 1 to 16");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic port_enable;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [TRIG_W-1:0] trig_width;
  logic [NUM_CMDS-1:0] soft_cmd;
  logic [15:0] cmd_count;
  logic [NUM_CMDS-1:0] pin_fall;
  logic [NUM_CMDS-1:0] pin_cmd;
  logic [NUM_CMDS-1:0] next_cmd;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  logic tick;
  logic [TRIG_W-1:0] trig_cnt;
  logic limiter_now;
  logic limiter_prev;
  logic ignored;
  logic dp_write;
  logic [7:0] dp_addr;
  logic addr_phase;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_trig_width;
  logic wr_soft_cmd;

  // ****************************************************************
  // Command inputs
  // ****************************************************************
  assign pin_cmd = {seq_branch2_n, seq_branch1_n, seq_hold_n, seq_stop_n, seq_start_n,
                    output_on_n, output_off_n};

  ecp_fall_detect #(
    .N(NUM_CMDS)
  ) u_fall (
    .hclk(hclk),
    .hresetn(hresetn),
    .din_n(pin_cmd),
    .fall(pin_fall)
  );

  // Pin edges are dropped while the port is off; software commands are not
  assign next_cmd = (port_enable ? pin_fall : '0) | soft_cmd; // R07
  assign ignored = ~port_enable & (|pin_fall); // R07

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= '0;
    end else begin
      cmd <= ecp_cmd_t'(next_cmd); // R06 R08
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_count <= 16'h0000;
    end else if (|next_cmd) begin
      cmd_count <= cmd_count + 16'h0001;
    end
  end

  // ****************************************************************
  // Status pins
  // ****************************************************************
  assign limiter_now = engine.lim_pos_peak | engine.lim_neg_peak | engine.lim_avg | engine.lim_power; // R04

  // Pins read low while the port is disabled so a wired controller sees no stale state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins.power_state <= 1'b0;
      pins.output_state <= 1'b0;
      pins.limiter <= 1'b0;
      pins.busy <= 1'b0;
      pins.seq_sync <= 3'h0;
    end else begin
      pins.power_state <= port_enable & engine.power_on; // R01
      pins.output_state <= port_enable & engine.output_on; // R02
      pins.limiter <= port_enable & limiter_now; // R04
      pins.busy <= port_enable & engine.busy; // R03
      pins.seq_sync <= port_enable ? engine.sync_code : 3'h0; // R05
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limiter_prev <= 1'b0;
    end else begin
      limiter_prev <= limiter_now;
    end
  end

  // ****************************************************************
  // Trigger output pulse
  // ****************************************************************
  ecp_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // A new request restarts the pulse; width zero still gives one tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_cnt <= '0;
    end else if (trigger_req && port_enable) begin
      trig_cnt <= (trig_width == '0) ? TRIG_W'(1) : trig_width;
    end else if (tick && trig_cnt != '0) begin
      trig_cnt <= trig_cnt - TRIG_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins.trigger <= 1'b0;
    end else begin
      pins.trigger <= port_enable & (trig_cnt != '0); // R07
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; every access completes OKAY, unmapped reads give zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= addr_phase & hwrite;
      if (addr_phase) begin
        dp_addr <= {haddr[7:2], 2'b00};
      end
    end
  end

  assign wr_ctrl = dp_write & (dp_addr == ADDR_CTRL);
  assign wr_irq_status = dp_write & (dp_addr == ADDR_IRQ_STATUS);
  assign wr_irq_mask = dp_write & (dp_addr == ADDR_IRQ_MASK);
  assign wr_trig_width = dp_write & (dp_addr == ADDR_TRIG_WIDTH);
  assign wr_soft_cmd = dp_write & (dp_addr == ADDR_SOFT_CMD);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_POWER_BIT] = engine.power_on;
    status_word[ST_OUTPUT_BIT] = engine.output_on;
    status_word[ST_LIMITER_BIT] = limiter_now;
    status_word[ST_BUSY_BIT] = engine.busy;
    status_word[ST_SYNC_LSB +: 3] = engine.sync_code;
    status_word[ST_LIMSRC_LSB +: 4] = {engine.lim_power, engine.lim_avg, engine.lim_neg_peak, engine.lim_pos_peak};
    status_word[ST_ENABLE_BIT] = port_enable;
    status_word[ST_TRIG_BIT] = pins.trigger;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      ADDR_CTRL: next_rdata[CTRL_ENABLE_BIT] = port_enable;
      ADDR_STATUS: next_rdata = status_word;
      ADDR_IRQ_STATUS: next_rdata[IRQ_BITS-1:0] = irq_status;
      ADDR_IRQ_MASK: next_rdata[IRQ_BITS-1:0] = irq_mask;
      ADDR_TRIG_WIDTH: next_rdata[TRIG_W-1:0] = trig_width;
      ADDR_CMD_COUNT: next_rdata[15:0] = cmd_count;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the address phase so it stands for the whole data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_enable <= CTRL_ENABLE_RST;
    end else if (wr_ctrl) begin
      port_enable <= hwdata[CTRL_ENABLE_BIT]; // R07
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask <= hwdata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_width <= TRIG_W'(TRIG_WIDTH_RST);
    end else if (wr_trig_width) begin
      trig_width <= hwdata[TRIG_W-1:0];
    end
  end

  // Self-clearing: a write issues each set bit as a one-cycle command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_cmd <= '0;
    end else begin
      soft_cmd <= wr_soft_cmd ? hwdata[NUM_CMDS-1:0] : '0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb begin
    irq_set = '0;
    irq_set[NUM_CMDS-1:0] = next_cmd;
    irq_set[IRQ_LIMITER_BIT] = limiter_now & ~limiter_prev;
    irq_set[IRQ_IGNORED_BIT] = ignored;
  end

  assign irq_clr = wr_irq_status ? hwdata[IRQ_BITS-1:0] : '0;

  // Set wins over a simultaneous write-one-to-clear so no event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// *** hw/ecp_pkg.sv ***
// Functional notes
// R01: Power-state pin is high while the unit is powered on, low while off. Here the pin reads low while the port is disabled.
// R02: Output-state pin is high while the power output is enabled, low otherwise. Here the pin reads low while the port is disabled.
// R03: Busy pin is high while internal processing is busy, low when idle. Here the pin reads low while the port is disabled.
// R04: Limiter pin is high while any of the four limiters acts, low otherwise. Here the pin reads low while the port is disabled.
// R05: Three sync pins, bits 0 to 2, carry the running sequence step code. Here they read zero while the port is disabled.
// R06: Each command input acts only on its high-to-low transition.
// R07: Port commands are honoured only once the external port enable is set.
// R08: Command inputs pass two synchroniser flops; each falling edge gives one pulse.
package ecp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int TRIG_WIDTH_BITS = 8;
  localparam logic [7:0] TRIG_WIDTH_RST = 8'h0a;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_TRIG_WIDTH = 8'h10;
  localparam logic [7:0] ADDR_SOFT_CMD = 8'h14;
  localparam logic [7:0] ADDR_CMD_COUNT = 8'h18;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RST = 1'b0;

  localparam int NUM_CMDS = 7;
  localparam int IRQ_BITS = 9;
  localparam int IRQ_LIMITER_BIT = 7;
  localparam int IRQ_IGNORED_BIT = 8;
  localparam logic [8:0] IRQ_MASK_RST = 9'h000;

  // Status register field positions
  localparam int ST_POWER_BIT = 0;
  localparam int ST_OUTPUT_BIT = 1;
  localparam int ST_LIMITER_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_SYNC_LSB = 4;
  localparam int ST_LIMSRC_LSB = 8;
  localparam int ST_ENABLE_BIT = 12;
  localparam int ST_TRIG_BIT = 13;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Bit order matches the command index used in irq and soft-command fields
  typedef struct packed {
    logic branch2;
    logic branch1;
    logic hold;
    logic stop;
    logic start;
    logic out_on;
    logic out_off;
  } ecp_cmd_t;

  typedef struct packed {
    logic power_on;
    logic output_on;
    logic busy;
    logic lim_pos_peak;
    logic lim_neg_peak;
    logic lim_avg;
    logic lim_power;
    logic [2:0] sync_code;
  } ecp_engine_t;

  typedef struct packed {
    logic power_state;
    logic output_state;
    logic limiter;
    logic busy;
    logic [2:0] seq_sync;
    logic trigger;
  } ecp_pins_t;

endpackage

// *** hw/ecp_fall_detect.sv ***
module ecp_fall_detect import ecp_pkg::*; #(
  parameter int N = NUM_CMDS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N-1:0] din_n,
  output logic [N-1:0] fall
);

  if (N < 1) begin : g_chk
    $error("ecp_fall_detect: N must be at least 1");
  end

  // ****************************************************************
  // Two-flop synchroniser and edge detector per input
  // ****************************************************************
  for (genvar i = 0; i < N; i++) begin : g_bit
    logic meta;
    logic sync;
    logic prev;
    // Idle level is high (pulled up), so reset to 1 to avoid a false edge
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta <= 1'b1;
        sync <= 1'b1;
        prev <= 1'b1;
        fall[i] <= 1'b0;
      end else begin
        meta <= din_n[i]; // R08
        sync <= meta; // R08
        prev <= sync;
        fall[i] <= prev & ~sync; // R06 R08
      end
    end
  end

endmodule

// *** hw/ecp_tick_div.sv ***
module ecp_tick_div import ecp_pkg::*; #(
  parameter int DIV = TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 1) begin : g_chk
    $error("ecp_tick_div: DIV must be at least 1");
  end

  logic [CW-1:0] cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end

endmodule

// *** tb/ecp_ctl_model.sv ***
module ecp_ctl_model (
  input wire logic hclk,
  output logic [6:0] pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines rest high on the pull-up between commands
  initial pin_n = 7'h7f;
  task automatic strobe(input int i, input int low);
    @(posedge hclk);
    pin_n[i] <= 1'b0;
    repeat (low) @(posedge hclk);
    pin_n[i] <= 1'b1;
  endtask
endmodule

// *** tb/ecp_top_chk.sv ***
module ecp_top_chk import ecp_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [6:0] pn,
  input wire ecp_engine_t engine,
  input wire ecp_cmd_t cmd,
  input wire ecp_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en;
  logic wr_ctrl;
  logic lim_any;
  ecp_engine_t eg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // The enable bit is internal, so a copy is kept from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl <= 1'b0;
      en <= 1'b0;
    end else begin
      wr_ctrl <= hsel && htrans[1] && hready && hwrite && haddr[7:2] == ADDR_CTRL[7:2];
      if (wr_ctrl) en <= hwdata[CTRL_ENABLE_BIT];
    end
  end
  assign eg = en ? engine : '0;
  assign lim_any = eg.lim_pos_peak | eg.lim_neg_peak | eg.lim_avg | eg.lim_power;
  sequence s_one(b);
    b ##1 !b;
  endsequence
  chk_power_pin: assert property (pins.power_state == $past(eg.power_on))
    else $error("power pin wrong");
  chk_output_pin: assert property (pins.output_state == $past(eg.output_on))
    else $error("output pin wrong");
  chk_busy_pin: assert property (pins.busy == $past(eg.busy))
    else $error("busy pin wrong");
  chk_limiter_or: assert property (pins.limiter == $past(lim_any))
    else $error("limiter pin wrong");
  chk_sync_code: assert property (pins.seq_sync == $past(eg.sync_code))
    else $error("sync pins wrong");
  chk_pins_quiet: assert property (!$past(en) |-> pins == '0)
    else $error("pins driven while disabled");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  for (genvar i = 0; i < 7; i++) begin : g_cmd
    chk_cmd_edge: assert property ($fell(pn[i]) && en |-> ##4 s_one(cmd[i]))
      else $error("command pulse missing");
    chk_cmd_refused: assert property ($fell(pn[i]) && !en |-> ##4 !cmd[i])
      else $error("command while disabled");
    chk_cmd_rise: assert property ($rose(pn[i]) |-> ##4 !cmd[i])
      else $error("command on rising edge");
  end
endmodule

bind ecp_top ecp_top_chk u_ecp_top_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .engine(engine), .cmd(cmd),
  .pins(pins), .pn({seq_branch2_n, seq_branch1_n, seq_hold_n, seq_stop_n, seq_start_n, output_on_n, output_off_n})
);

// *** tb/tb_ecp_top.sv ***
module tb_ecp_top import ecp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [9:0] eng;
    logic [7:0] exp;
  } ecp_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  ecp_engine_t engine = '0;
  ecp_cmd_t cmd;
  ecp_pins_t pins;
  logic [6:0] pin_n;
  logic [6:0] seen = '0;
  logic clr = 1'b0;
  logic trig = 1'b0;
  int trig_len = 0;
  int bad_count = 0;
  int num_checks = 0;
  ecp_row_t rows [11] = '{'{10'h200, 8'h80}, '{10'h100, 8'h40}, '{10'h080, 8'h10}, '{10'h040, 8'h20},
    '{10'h020, 8'h20}, '{10'h010, 8'h20}, '{10'h008, 8'h20}, '{10'h000, 8'h00}, '{10'h005, 8'h0a},
    '{10'h002, 8'h04}, '{10'h3ff, 8'hfe}};

  always #25 hclk = ~hclk;
  // Commands are caught here so a one-cycle pulse is never missed by a task
  always @(posedge hclk) seen <= clr ? 7'h00 : seen | cmd;

  ecp_top u_ecp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .output_off_n(pin_n[0]), .output_on_n(pin_n[1]), .seq_start_n(pin_n[2]),
    .seq_stop_n(pin_n[3]), .seq_hold_n(pin_n[4]), .seq_branch1_n(pin_n[5]), .seq_branch2_n(pin_n[6]),
    .engine(engine), .trigger_req(trig), .cmd(cmd), .pins(pins), .irq(irq));
  ecp_ctl_model u_ecp_ctl_model (.hclk(hclk), .pin_n(pin_n));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rdy;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      finish_test;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(q, exp);
  endtask
  task automatic clear_seen;
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(pins), 0);
    chk(32'(cmd), 0);
    rd(ADDR_CTRL, 0);
    rd(ADDR_IRQ_MASK, 0);
    rd(ADDR_TRIG_WIDTH, 32'(TRIG_WIDTH_RST));
    rd(8'h40, 0);
    $display("test reset done");
    wr(ADDR_CTRL, 1);
    foreach (rows[i]) begin
      @(posedge hclk);
      engine <= rows[i].eng;
      repeat (2) @(posedge hclk);
      chk(32'(pins), 32'(rows[i].exp));
    end
    rd(ADDR_STATUS, 32'h0000_1f7f);
    $display("test pins done");
    // Pulse length depends on the free-running tick phase, so a window is accepted
    wr(ADDR_TRIG_WIDTH, 32'h2);
    rd(ADDR_TRIG_WIDTH, 32'h2);
    trig <= 1'b1;
    @(posedge hclk);
    trig <= 1'b0;
    repeat (2) @(posedge hclk);
    while (pins.trigger === 1'b1 && trig_len < 100) begin
      @(posedge hclk);
      trig_len++;
    end
    chk(32'(trig_len > TICK_CYCLES && trig_len <= 2 * TICK_CYCLES), 1);
    $display("test trigger done");
    for (int i = 0; i < 7; i++) begin
      clear_seen;
      u_ecp_ctl_model.strobe(i, 3);
      repeat (8) @(posedge hclk);
      chk(32'(seen), 32'(1) << i);
    end
    // Limiter rises during the pin rows also latch their own event bit
    rd(ADDR_IRQ_STATUS, 32'hff);
    rd(ADDR_CMD_COUNT, 32'h7);
    chk(32'(irq), 0);
    wr(ADDR_IRQ_MASK, 32'h1ff);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 1);
    wr(ADDR_IRQ_STATUS, 32'h1ff);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 0);
    $display("test commands done");
    wr(ADDR_CTRL, 0);
    clear_seen;
    u_ecp_ctl_model.strobe(3, 3);
    repeat (8) @(posedge hclk);
    chk(32'(seen), 0);
    chk(32'(pins), 0);
    rd(ADDR_IRQ_STATUS, 32'h100);
    chk(32'(irq), 1);
    clear_seen;
    wr(ADDR_SOFT_CMD, 32'h04);
    repeat (3) @(posedge hclk);
    chk(32'(seen), 32'h04);
    $display("test disabled done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'(irq), 0);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 0);
    $display("test rereset done");
    finish_test;
  end
endmodule
